// ---- sfpe_flash_seq.sv ----
// Serial flash quad page program and sector/block erase sequencer
`include "sfpe_regs.svh"
module sfpe_flash_seq
	import sfpe_pkg::*;
#(
	parameter int ADDR_W = 26,
	parameter int unsigned PROG_CYCLES =
		`SFPE_PROG_TIME_US * 1000 / `SFPE_CLK_PERIOD_NS,
	parameter int unsigned SECT_CYCLES =
		`SFPE_SECT_TIME_US * 1000 / `SFPE_CLK_PERIOD_NS,
	parameter int unsigned SBLK_CYCLES =
		`SFPE_SBLK_TIME_US * 1000 / `SFPE_CLK_PERIOD_NS,
	parameter int unsigned LBLK_CYCLES =
		`SFPE_LBLK_TIME_US * 1000 / `SFPE_CLK_PERIOD_NS
) (
	// System
	input wire logic mclk,
	input wire logic sys_rst,
	// Serial link
	input wire logic linkClk,
	input wire logic csN,
	input wire logic [3:0] laneIn,
	// Configuration and status
	input wire logic fourByteMode,
	input wire logic [4:0] protectBits,
	output logic writeEnableLatch,
	output logic writeInProgress,
	// Array side
	output sfpe_arr_t arrReq
);

	generate
		if (ADDR_W < 17 || ADDR_W > 32) begin : g_chk
			$error("ADDR_W must lie in 17..32");
		end
		if (PROG_CYCLES < 1 || SECT_CYCLES < 1 || SBLK_CYCLES < 1 || LBLK_CYCLES < 1) begin : g_chk2
			$error("cycle counts must be at least one");
		end
	endgenerate

	// Link domain
	logic frameOn;
	logic [1:0] busyLk;
	logic [1:0] fourLk;
	sfpe_frame_t lf;
	logic [3:0] hiNib;
	logic [7:0] bufPtr;
	logic [7:0] pageBuf [256];
	logic [255:0] byteMask;
	logic [5:0] addrBitsLk;
	logic quadOp;
	logic [7:0] wrIdx;

	// Cleared by the frame's own deselect, so no link edge is needed after it
	always_ff @(posedge linkClk or posedge csN) begin
		if (csN) begin
			frameOn <= 1'b0;
		end else begin
			frameOn <= 1'b1;
		end
	end

	always_ff @(posedge linkClk) begin
		busyLk <= {busyLk[0], writeInProgress};
		fourLk <= {fourLk[0], fourByteMode};
	end

	assign addrBitsLk = fourLk[1] ? `SFPE_ADDR4_BITS : `SFPE_ADDR3_BITS;
	assign quadOp = lf.opcode == `SFPE_OP_QPROG_A || lf.opcode == `SFPE_OP_QPROG_B;
	assign wrIdx = lf.gotData ? bufPtr : lf.addr[7:0];

	always_ff @(posedge linkClk) begin
		if (!frameOn) begin
			lf.opcode <= {7'h00, laneIn[0]};
			lf.addr <= '0;
			lf.bits <= 6'd1;
			lf.gotData <= 1'b0;
			lf.halfByte <= 1'b0;
		end else if (lf.bits < `SFPE_CMD_BITS) begin
			lf.opcode <= {lf.opcode[6:0], laneIn[0]};
			lf.bits <= lf.bits + 6'd1;
		end else if (!quadOp || lf.bits < `SFPE_CMD_BITS + addrBitsLk) begin
			// Erase frames keep counting so trailing bits cancel them
			lf.addr <= {lf.addr[30:0], laneIn[0]};
			if (lf.bits != 6'h3F) begin
				lf.bits <= lf.bits + 6'd1;
			end
		end else begin
			lf.halfByte <= ~lf.halfByte;
			if (lf.halfByte) begin
				lf.gotData <= 1'b1;
			end
		end
	end

	// Page buffer; frozen while a cycle runs so program frames sent meanwhile cannot corrupt it
	always_ff @(posedge linkClk) begin
		if (frameOn && quadOp && lf.bits >= `SFPE_CMD_BITS + addrBitsLk
				&& !busyLk[1]) begin
			if (!lf.halfByte) begin
				hiNib <= laneIn;
			end else begin
				pageBuf[wrIdx] <= {hiNib, laneIn};
				bufPtr <= wrIdx + 8'h01;
			end
		end
	end

	// Mask restarts at the first byte, not at select, since busy lags there
	always_ff @(posedge linkClk) begin
		if (frameOn && quadOp && lf.halfByte && !busyLk[1]) begin
			if (!lf.gotData) begin
				byteMask <= 256'(1) << wrIdx;
			end else begin
				byteMask[wrIdx] <= 1'b1;
			end
		end
	end

	// System domain
	logic [1:0] csSync;
	logic csPrev;
	logic frameEnd;
	sfpe_state_t state;
	sfpe_op_t kind;
	sfpe_op_t opKind;
	logic isProg;
	logic isErase;
	logic exactAddr;
	logic progOk;
	logic eraseOk;
	logic wrEnFrame;
	logic prot;
	logic start;
	logic [31:0] tgtAddr;
	logic [31:0] opAddr;
	logic [31:0] timer;
	logic [7:0] walkIdx;
	logic [5:0] addrBits;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			csSync <= 2'b11;
			csPrev <= 1'b1;
		end else begin
			csSync <= {csSync[0], csN};
			csPrev <= csSync[1];
		end
	end

	// Frame words are quasi-static here: the link clock is idle while deselected
	assign frameEnd = csSync[1] & ~csPrev;
	assign addrBits = fourByteMode ? `SFPE_ADDR4_BITS : `SFPE_ADDR3_BITS;
	assign exactAddr = lf.bits == `SFPE_CMD_BITS + addrBits;
	assign tgtAddr = fourByteMode ? lf.addr : {8'h00, lf.addr[23:0]};

	always_comb begin
		kind = SFPE_PROG;
		isProg = 1'b0;
		isErase = 1'b1;
		case (lf.opcode)
			`SFPE_OP_QPROG_A, `SFPE_OP_QPROG_B: begin
				isProg = 1'b1;
				isErase = 1'b0;
			end
			`SFPE_OP_SECT_A, `SFPE_OP_SECT_B: kind = SFPE_SECT;
			`SFPE_OP_SBLK_A, `SFPE_OP_SBLK_B: kind = SFPE_SBLK;
			`SFPE_OP_LBLK_A, `SFPE_OP_LBLK_B: kind = SFPE_LBLK;
			default: isErase = 1'b0;
		endcase
	end

	assign progOk = isProg & exactAddr & lf.gotData & ~lf.halfByte;
	assign eraseOk = isErase & exactAddr & ~lf.gotData;
	assign wrEnFrame = lf.opcode == `SFPE_OP_WR_ENABLE && lf.bits == `SFPE_CMD_BITS;

	// Protected span counts 64KB units from the top, or the bottom with bit 4
	function automatic logic protHit(input logic [31:0] a, input logic [4:0] bp);
		logic [ADDR_W-1:0] inDev;
		logic [31:0] blk;
		logic [31:0] total;
		logic [31:0] span;
		inDev = a[ADDR_W-1:0];
		blk = 32'(inDev >> `SFPE_PROT_LSB);
		total = 32'(1) << (ADDR_W - `SFPE_PROT_LSB);
		span = (bp[3:0] == 4'h0) ? 32'h0 : 32'(1) << (bp[3:0] - 4'h1);
		if (span > total) begin
			span = total;
		end
		protHit = bp[4] ? (blk < span) : (blk >= total - span);
	endfunction

	assign prot = protHit(tgtAddr, protectBits);
	assign start = frameEnd && state == SFPE_IDLE && writeEnableLatch
		&& (progOk || eraseOk) && !prot;

	function automatic logic [31:0] alignMask(input sfpe_op_t k);
		case (k)
			SFPE_SECT: alignMask = ~((32'(1) << `SFPE_SECT_LSB) - 32'h1);
			SFPE_SBLK: alignMask = ~((32'(1) << `SFPE_SBLK_LSB) - 32'h1);
			SFPE_LBLK: alignMask = ~((32'(1) << `SFPE_LBLK_LSB) - 32'h1);
			default: alignMask = ~((32'(1) << `SFPE_PAGE_LSB) - 32'h1);
		endcase
	endfunction

	// Write-enable latch: cleared as the cycle starts, set by its command
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			writeEnableLatch <= 1'b0;
		end else if (frameEnd && state == SFPE_IDLE && wrEnFrame) begin
			writeEnableLatch <= 1'b1;
		end else if (start) begin
			writeEnableLatch <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state <= SFPE_IDLE;
			writeInProgress <= 1'b0;
			timer <= '0;
			walkIdx <= '0;
			opAddr <= '0;
			opKind <= SFPE_PROG;
		end else begin
			case (state)
				SFPE_IDLE: begin
					if (start) begin
						writeInProgress <= 1'b1;
						opAddr <= tgtAddr & alignMask(isProg ? SFPE_PROG : kind);
						opKind <= isProg ? SFPE_PROG : kind;
						walkIdx <= '0;
						if (isProg) begin
							state <= SFPE_WALK;
							timer <= PROG_CYCLES;
						end else begin
							state <= SFPE_WAIT;
							timer <= kind == SFPE_SECT ? SECT_CYCLES
								: kind == SFPE_SBLK ? SBLK_CYCLES : LBLK_CYCLES;
						end
					end
				end
				SFPE_WALK: begin
					walkIdx <= walkIdx + 8'h01;
					if (walkIdx == 8'hFF) begin
						state <= SFPE_WAIT;
					end
				end
				default: begin
					if (timer <= 32'h1) begin
						state <= SFPE_IDLE;
						writeInProgress <= 1'b0;
					end else begin
						timer <= timer - 32'h1;
					end
				end
			endcase
		end
	end

	// Only bytes actually received are written; the rest of the page is left
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			arrReq <= '0;
		end else begin
			arrReq.wr <= state == SFPE_WALK && byteMask[walkIdx];
			arrReq.erase <= start && isErase;
			arrReq.kind <= isProg ? SFPE_PROG : kind;
			if (state == SFPE_WALK) begin
				arrReq.kind <= SFPE_PROG;
				arrReq.addr <= {opAddr[31:8], walkIdx};
				arrReq.data <= pageBuf[walkIdx];
			end else begin
				arrReq.addr <= tgtAddr & alignMask(kind);
				arrReq.data <= 8'h00;
			end
		end
	end

	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	sequence s_progStart;
		start && isProg;
	endsequence
	sequence s_walkDone;
		(state == SFPE_WALK && walkIdx == 8'hFF) ##1 (state == SFPE_WAIT);
	endsequence

	property p_wel_needed;
		$rose(writeInProgress) |-> $past(writeEnableLatch);
	endproperty
	a_wel_needed: assert property (p_wel_needed) else $error("cycle without latch");

	property p_wel_clear;
		$rose(writeInProgress) |-> !writeEnableLatch;
	endproperty
	a_wel_clear: assert property (p_wel_clear) else $error("latch not cleared");

	property p_prog_walk;
		s_progStart |-> ##256 s_walkDone;
	endproperty
	a_prog_walk: assert property (p_prog_walk) else $error("page walk length wrong");

	property p_prog_busy;
		s_progStart |=> writeInProgress [*8];
	endproperty
	a_prog_busy: assert property (p_prog_busy) else $error("busy not shown");

	property p_prog_frame;
		frameEnd && isProg && !progOk |=> $stable(writeInProgress);
	endproperty
	a_prog_frame: assert property (p_prog_frame) else $error("bad frame programmed");

	property p_prot_prog;
		frameEnd && isProg && prot |=> $stable(writeInProgress);
	endproperty
	a_prot_prog: assert property (p_prot_prog) else $error("protected page programmed");

	property p_erase_frame;
		frameEnd && isErase && !eraseOk |=> !arrReq.erase;
	endproperty
	a_erase_frame: assert property (p_erase_frame) else $error("bad frame erased");

	property p_prot_erase;
		frameEnd && isErase && prot |=> !arrReq.erase;
	endproperty
	a_prot_erase: assert property (p_prot_erase) else $error("protected area erased");

	property p_sect_align;
		arrReq.erase && arrReq.kind == SFPE_SECT |-> arrReq.addr[11:0] == 12'h000;
	endproperty
	a_sect_align: assert property (p_sect_align) else $error("sector not aligned");

	property p_erase_busy;
		start && isErase |=> writeInProgress && arrReq.erase;
	endproperty
	a_erase_busy: assert property (p_erase_busy) else $error("erase not started");

	property p_wrap;
		arrReq.wr |-> arrReq.addr[31:8] == opAddr[31:8];
	endproperty
	a_wrap: assert property (p_wrap) else $error("write left its page");

endmodule

// ---- sfpe_regs.svh ----
// Constants for the serial flash program/erase sequencer
// Functional notes
// - Quad program: opcode, address, four-lane data
// - Program or erase needs write-enable latch set
// - Over 256 bytes: keep last 256 only
// - Under 256 bytes: other page bytes untouched
// - Program runs only on byte-aligned deselect
// - Program sets busy flag until cycle ends
// - Write-enable latch clears during every cycle
// - Protected page is never programmed
// - Sector erase: opcode and address, no data
// - Any address erases its whole sector
// - Sector erase only on byte-aligned deselect
// - Sector erase sets busy until done
// - Protected sector is never erased
// - Small block erase clears whole 32KB block
// - Large block erase clears whole 64KB block
// - Block erase only on byte-aligned deselect
// - Block erase busy flag, protection refused
// - Address is 24 bits, or 32 in four-byte mode
// - Page data wraps to page start
`ifndef SFPE_REGS_SVH
`define SFPE_REGS_SVH
`define SFPE_OP_WR_ENABLE 8'h06
`define SFPE_OP_QPROG_A 8'h32
`define SFPE_OP_QPROG_B 8'h34
`define SFPE_OP_SECT_A 8'h20
`define SFPE_OP_SECT_B 8'h21
`define SFPE_OP_SBLK_A 8'h52
`define SFPE_OP_SBLK_B 8'h5C
`define SFPE_OP_LBLK_A 8'hD8
`define SFPE_OP_LBLK_B 8'hDC
`define SFPE_CMD_BITS 6'd8
`define SFPE_ADDR3_BITS 6'd24
`define SFPE_ADDR4_BITS 6'd32
`define SFPE_PAGE_LSB 8
`define SFPE_SECT_LSB 12
`define SFPE_SBLK_LSB 15
`define SFPE_LBLK_LSB 16
`define SFPE_PROT_LSB 16
`define SFPE_CLK_PERIOD_NS 40
`define SFPE_PROG_TIME_US 600
`define SFPE_SECT_TIME_US 50000
`define SFPE_SBLK_TIME_US 150000
`define SFPE_LBLK_TIME_US 200000
`endif

// ---- sfpe_pkg.sv ----
// Types shared by the serial flash program/erase sequencer
package sfpe_pkg;
	typedef enum logic [1:0] {SFPE_PROG, SFPE_SECT, SFPE_SBLK, SFPE_LBLK} sfpe_op_t;
	typedef enum {SFPE_IDLE, SFPE_WALK, SFPE_WAIT} sfpe_state_t;
	typedef struct packed {
		logic [7:0] opcode;
		logic [31:0] addr;
		logic [5:0] bits;
		logic gotData;
		logic halfByte;
	} sfpe_frame_t;
	typedef struct packed {
		logic wr;
		logic erase;
		sfpe_op_t kind;
		logic [31:0] addr;
		logic [7:0] data;
	} sfpe_arr_t;
endpackage

// ---- sfpe_host_model.sv ----
// Host controller model: drives select, link clock and the four data lanes
module sfpe_host_model (
	// Serial link
	output logic linkClk,
	output logic csN,
	output logic [3:0] laneIn
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		linkClk = 1'b0;
		csN = 1'b1;
		laneIn = 4'h0;
	end
	// Link clock runs only inside frames, so it stands low between them
	task automatic tick(input logic [3:0] v);
		laneIn = v;
		#40 linkClk = 1'b1;
		#40 linkClk = 1'b0;
	endtask
	task automatic frame(input logic [7:0] op, input logic [31:0] adr, input int aw,
		input int nb, input logic [7:0] seed, input bit odd);
		logic [7:0] d;
		#13 csN = 1'b0;
		for (int i = 7; i >= 0; i--) tick({3'h0, op[i]});
		for (int i = aw - 1; i >= 0; i--) tick({3'h0, adr[i]});
		for (int b = 0; b < nb; b++) begin
			d = seed + 8'(b);
			tick(d[7:4]);
			tick(d[3:0]);
		end
		// A trailing half byte breaks the byte boundary on purpose
		if (odd) tick(seed[7:4]);
		#20 csN = 1'b1;
		// Released lanes show the inverse so a stale value cannot pass
		laneIn = ~laneIn;
	endtask
endmodule

// ---- sfpe_flash_seq_tb_top.sv ----
// Self-checking testbench for the program/erase sequencer
module sfpe_flash_seq_tb_top;
	import sfpe_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic fourByteMode = 1'b0;
	logic [4:0] protectBits = 5'h00;
	wire linkClk;
	wire csN;
	wire [3:0] laneIn;
	logic writeEnableLatch;
	logic writeInProgress;
	sfpe_arr_t arrReq;
	sfpe_arr_t expQ[$];
	sfpe_arr_t e;
	int num_errors = 0;
	int check_count = 0;
	logic [31:0] lfsr = 32'h6B71;
	logic [7:0] ops[6] = '{8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC};
	sfpe_op_t kinds[6] = '{SFPE_SECT, SFPE_SECT, SFPE_SBLK, SFPE_SBLK, SFPE_LBLK, SFPE_LBLK};
	int lsbs[6] = '{12, 12, 15, 15, 16, 16};
	always #20 mclk = ~mclk;
	// Short cycle counts keep the run brief
	sfpe_flash_seq #(.ADDR_W(26), .PROG_CYCLES(20), .SECT_CYCLES(20), .SBLK_CYCLES(20),
		.LBLK_CYCLES(20)) i_sfpe_flash_seq (.mclk(mclk), .sys_rst(sys_rst),
		.linkClk(linkClk), .csN(csN), .laneIn(laneIn), .fourByteMode(fourByteMode),
		.protectBits(protectBits), .writeEnableLatch(writeEnableLatch),
		.writeInProgress(writeInProgress), .arrReq(arrReq));
	sfpe_host_model i_sfpe_host_model (.linkClk(linkClk), .csN(csN), .laneIn(laneIn));
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	task automatic wait_mclk(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic op(input logic [7:0] opc, input logic [31:0] adr, input int aw, input int nb,
		input sfpe_op_t kind, input int lsb, input bit write_enable_cmd, input bit odd, input bit ok);
		logic [7:0] seed;
		logic [7:0] pg[256];
		bit v[256];
		bit seen;
		int n;
		seed = 8'(rnd());
		if (ok && kind == SFPE_PROG) begin
			for (int i = 0; i < nb; i++) begin
				pg[8'(adr + 32'(i))] = seed + 8'(i);
				v[8'(adr + 32'(i))] = 1'b1;
			end
			for (int i = 0; i < 256; i++) begin
				if (v[i]) expQ.push_back(sfpe_arr_t'{1'b1, 1'b0, SFPE_PROG, {adr[31:8], 8'(i)}, pg[i]});
			end
		end else if (ok) begin
			expQ.push_back(sfpe_arr_t'{1'b0, 1'b1, kind, adr & ~((32'h1 << lsb) - 32'h1), 8'h00});
		end
		if (write_enable_cmd) begin
			i_sfpe_host_model.frame(8'h06, 32'h0, 0, 0, 8'h00, 1'b0);
			wait_mclk(8);
			check("write enable latch", 32'(writeEnableLatch), 32'h1);
		end
		i_sfpe_host_model.frame(opc, adr, aw, nb, seed, odd);
		seen = 1'b0;
		for (n = 0; n < 20 && !seen; n++) begin
			@(posedge mclk);
			#1 seen = (writeInProgress === 1'b1);
		end
		for (n = 0; n < 1000 && writeInProgress !== 1'b0; n++) @(posedge mclk);
		if (n == 1000) begin
			check("busy timeout", 32'h1, 32'h0);
			give_verdict();
		end
		wait_mclk(8);
		check("busy seen", 32'(seen), 32'(ok));
		check("latch after", 32'(writeEnableLatch), 32'(write_enable_cmd & ~ok));
		check("pending array requests", 32'(expQ.size()), 32'h0);
	endtask
	// Sampled mid-cycle so the registered request has settled
	always @(negedge mclk) begin
		if (arrReq.wr === 1'b1 || arrReq.erase === 1'b1) begin
			if (expQ.size() == 0) begin
				check("unplanned array request", 32'h1, 32'h0);
			end else begin
				e = expQ.pop_front();
				check("array erase", 32'(arrReq.erase), 32'(e.erase));
				check("array address", arrReq.addr, e.addr);
				if (e.erase) check("array kind", 32'(arrReq.kind), 32'(e.kind));
				if (e.wr) check("array data", 32'(arrReq.data), 32'(e.data));
			end
		end
	end
	initial begin
		wait_mclk(2);
		sys_rst <= 1'b0;
		wait_mclk(5);
		op(8'h20, 32'h012345, 24, 0, SFPE_SECT, 12, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 6; i++) begin
			op(ops[i], rnd() & 32'hFFFFFF, 24, 0, kinds[i], lsbs[i], 1'b1, 1'b0, 1'b1);
		end
		op(8'h52, rnd() & 32'hFFFFFF, 23, 0, SFPE_SBLK, 15, 1'b1, 1'b0, 1'b0);
		op(8'h20, rnd() & 32'hFFFFFF, 25, 0, SFPE_SECT, 12, 1'b1, 1'b0, 1'b0);
		fourByteMode <= 1'b1;
		op(8'hDC, rnd() & 32'h3FFFFFF, 32, 0, SFPE_LBLK, 16, 1'b1, 1'b0, 1'b1);
		fourByteMode <= 1'b0;
		// Bottom 64KB unit protected; the next unit up must still erase
		protectBits <= 5'h11;
		op(8'hD8, 32'h001234, 24, 0, SFPE_LBLK, 16, 1'b1, 1'b0, 1'b0);
		op(8'h32, 32'h000100, 24, 4, SFPE_PROG, 8, 1'b1, 1'b0, 1'b0);
		op(8'h21, 32'h010000, 24, 0, SFPE_SECT, 12, 1'b1, 1'b0, 1'b1);
		protectBits <= 5'h00;
		op(8'h32, (rnd() & 32'hFFFF00) | 32'hF0, 24, 20, SFPE_PROG, 8, 1'b1, 1'b0, 1'b1);
		op(8'h34, rnd() & 32'hFFFFFF, 24, 260, SFPE_PROG, 8, 1'b1, 1'b0, 1'b1);
		op(8'h32, rnd() & 32'hFFFFFF, 24, 1, SFPE_PROG, 8, 1'b1, 1'b0, 1'b1);
		op(8'h34, rnd() & 32'hFFFFFF, 24, 3, SFPE_PROG, 8, 1'b1, 1'b1, 1'b0);
		give_verdict();
	end
endmodule
